// *** scgw_pkg.sv ***
// Scan gateway constants, register map and carrier types
package scgw_pkg;

  localparam int          scgw_ports         = 6;
  localparam logic [7:0]  scgw_ctrl_offset   = 8'h00;
  localparam logic [7:0]  scgw_state_offset  = 8'h04;
  localparam logic [7:0]  scgw_count_offset  = 8'h08;
  localparam int          scgw_ctrl_drive    = 0;
  localparam logic        scgw_ctrl_reset    = 1'b1;
  localparam int          scgw_st_chosen     = 0;
  localparam int          scgw_st_status     = 1;
  localparam int          scgw_st_slot       = 9;
  localparam int          scgw_st_route_on   = 15;
  localparam int          scgw_st_route_sel  = 16;
  localparam logic [3:0]  scgw_cmd_len       = 4'h8;
  localparam logic [1:0]  scgw_op_select     = 2'h0;
  localparam logic [1:0]  scgw_op_release    = 2'h1;
  localparam logic [1:0]  scgw_op_self_test  = 2'h2;
  localparam logic [1:0]  scgw_op_status     = 2'h3;
  localparam logic [2:0]  scgw_route_last    = 3'h5;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } scgw_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
  } scgw_ahb_rsp_t;

  typedef struct packed {
    logic [5:0] drive_oe;
    logic [5:0] fast_write_oe;
    logic [5:0] tck;
    logic [5:0] tms;
    logic [5:0] tdi;
    logic [5:0] trst_n;
    logic [5:0] fast_write;
    logic [5:0] debug_enable_n;
  } scgw_lsp_t;

endpackage : scgw_pkg

// *** scgw_top.sv ***
// Scan gateway pin control with AHB-Lite register access
//
// Contract
// - Port 6 fast write routed only on 101
// - Port 6 debug enable low only on 101
// - Upstream data out tri-stated unless chosen
// - Upstream test reset forces wait state asynchronously
// - Respond only at strapped slot address
// - Output enable low tri-states all ports
// - Port reset returns wait, pulses port resets
// - Chosen indication low while selected
// - Branch enabled low while selected
// - Capture eight status inputs, return over scan
// - Scan command emits one low self-test pulse
// - Route enable input high disables routing
// - Route select 000..101 picks ports 1..6
// - Unrouted: all ports while chosen; routed: selected only
`timescale 1ns/1ps
module scgw_top
  import scgw_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire scgw_pkg::scgw_ahb_req_t ahb_req,
  output      scgw_pkg::scgw_ahb_rsp_t ahb_rsp,
  input  wire logic                    upstream_test_clock,
  input  wire logic                    upstream_mode_in,
  input  wire logic                    upstream_data_in,
  input  wire logic                    upstream_test_reset_n,
  input  wire logic                    upstream_fast_write_in,
  output      logic                    upstream_data_out,
  output      logic                    upstream_data_out_oe,
  input  wire logic [5:0]              slot_address,
  input  wire logic                    port_output_enable_n,
  input  wire logic                    port_reset_n,
  input  wire logic                    direct_route_enable_n,
  input  wire logic [2:0]              direct_route_select,
  input  wire logic [7:0]              status_in,
  input  wire logic [5:0]              port_data_in,
  output      scgw_pkg::scgw_lsp_t     port_out,
  output      logic                    device_chosen_n,
  output      logic                    branch_enabled_n,
  output      logic                    self_test_n
);
  import scgw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain state

  typedef struct packed {
    logic [5:0] slot_s1;
    logic [5:0] slot_s2;
    logic [7:0] stat_s1;
    logic [7:0] stat_s2;
    logic [7:0] shift;
    logic [3:0] count;
    logic [7:0] out_sh;
    logic       chosen;
    logic       self_toggle;
  } scgw_link_t;

  scgw_link_t link;
  scgw_link_t next_link;
  logic       link_reset_n;

  // either reset pin clears link state
  // port reset joins the asynchronous clear
  assign link_reset_n = upstream_test_reset_n & port_reset_n;

  always_comb begin
    next_link         = link;
    next_link.slot_s1 = slot_address;
    next_link.slot_s2 = link.slot_s1;
    next_link.stat_s1 = status_in;
    next_link.stat_s2 = link.stat_s1;
    if (upstream_mode_in) begin
      next_link.shift  = {upstream_data_in, link.shift[7:1]};
      next_link.out_sh = {1'b1, link.out_sh[7:1]};
      if (link.count != scgw_cmd_len) begin
        next_link.count = link.count + 4'h1;
      end
    end else begin
      next_link.count = 4'h0;
      if (link.count == scgw_cmd_len) begin
        unique case (link.shift[7:6])
          scgw_op_select: begin
            next_link.chosen = (link.shift[5:0] == link.slot_s2);
          end
          scgw_op_release: begin
            next_link.chosen = 1'b0;
          end
          scgw_op_self_test: begin
            if (link.chosen) begin
              next_link.self_toggle = ~link.self_toggle;
            end
          end
          scgw_op_status: begin
            // load captured status for shift out
            if (link.chosen) begin
              next_link.out_sh = link.stat_s2;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge upstream_test_clock or negedge link_reset_n) begin
    if (!link_reset_n) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direct routing, combinational so the pins see no clock latency

  logic       route_on;
  logic [5:0] route_hit;
  logic       ports_allowed;
  logic       drive_allow;

  assign route_on = ~direct_route_enable_n;

  // one-hot port from the select code
  // codes above 101 give no port
  always_comb begin
    route_hit = 6'h00;
    if (direct_route_select <= scgw_route_last) begin
      route_hit[direct_route_select] = 1'b1;
    end
  end

  assign ports_allowed = port_output_enable_n & drive_allow;

  // pure gating, no flip-flop in the path
  always_comb begin
    // all ports unrouted while chosen, selected port routed
    port_out.drive_oe       = route_on ? route_hit & {6{ports_allowed}}
                                       : {6{ports_allowed & link.chosen}};
    port_out.tck            = {6{upstream_test_clock}};
    port_out.tms            = {6{upstream_mode_in}};
    port_out.tdi            = {6{upstream_data_in}};
    // port resets follow either reset pin low
    port_out.trst_n         = {6{link_reset_n}};
    // fast write only to the routed port
    port_out.fast_write_oe  = route_on ? route_hit & {6{ports_allowed}}
                                       : 6'h00;
    port_out.fast_write     = {6{upstream_fast_write_in}};
    // debug enable low on the routed port
    port_out.debug_enable_n = route_on ? ~route_hit : 6'h3f;
  end

  // data out driven only while chosen
  always_comb begin
    upstream_data_out_oe = link.chosen;
    upstream_data_out    = link.out_sh[0];
    if (route_on && (route_hit != 6'h00)) begin
      upstream_data_out = |(port_data_in & route_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus domain state

  typedef struct packed {
    logic        chosen_s1;
    logic        chosen_s2;
    logic        tog_s1;
    logic        tog_s2;
    logic        tog_s3;
    logic [7:0]  stat_s1;
    logic [7:0]  stat_s2;
    logic [5:0]  slot_s1;
    logic [5:0]  slot_s2;
    logic [3:0]  route_s1;
    logic [3:0]  route_s2;
    logic        drive;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic [7:0]  pulses;
    logic        self_test_n;
    logic        chosen_n;
    logic        branch_n;
  } scgw_bus_t;

  scgw_bus_t bus;
  scgw_bus_t next_bus;
  logic      addr_phase;
  logic [7:0] offset;

  function automatic logic [31:0] read_word(input scgw_bus_t b,
                                            input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      scgw_ctrl_offset: w[scgw_ctrl_drive] = b.drive;
      scgw_state_offset: begin
        w[scgw_st_chosen]                   = b.chosen_s2;
        w[scgw_st_status +: 8]              = b.stat_s2;
        w[scgw_st_slot +: 6]                = b.slot_s2;
        w[scgw_st_route_on]                 = ~b.route_s2[3];
        w[scgw_st_route_sel +: 3]           = b.route_s2[2:0];
      end
      scgw_count_offset: w[7:0] = b.pulses;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  assign addr_phase = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
  assign offset     = ahb_req.haddr[7:0];
  assign drive_allow = bus.drive;

  always_comb begin
    next_bus          = bus;
    next_bus.chosen_s1 = link.chosen;
    next_bus.chosen_s2 = bus.chosen_s1;
    next_bus.tog_s1    = link.self_toggle;
    next_bus.tog_s2    = bus.tog_s1;
    next_bus.tog_s3    = bus.tog_s2;
    next_bus.stat_s1   = status_in;
    next_bus.stat_s2   = bus.stat_s1;
    next_bus.slot_s1   = slot_address;
    next_bus.slot_s2   = bus.slot_s1;
    next_bus.route_s1  = {direct_route_enable_n, direct_route_select};
    next_bus.route_s2  = bus.route_s1;
    // one clock low per toggle edge
    next_bus.self_test_n = ~(bus.tog_s2 ^ bus.tog_s3);
    if (bus.tog_s2 != bus.tog_s3) begin
      next_bus.pulses = bus.pulses + 8'h01;
    end
    next_bus.chosen_n = ~bus.chosen_s2;
    next_bus.branch_n = ~bus.chosen_s2;
    next_bus.wr_pend  = addr_phase & ahb_req.hwrite;
    if (addr_phase) begin
      next_bus.wr_addr = offset;
      next_bus.rdata   = read_word(bus, offset);
    end
    if (bus.wr_pend && (bus.wr_addr == scgw_ctrl_offset)) begin
      next_bus.drive = ahb_req.hwdata[scgw_ctrl_drive];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus             <= '0;
      bus.drive       <= scgw_ctrl_reset;
      bus.self_test_n <= 1'b1;
      bus.chosen_n    <= 1'b1;
      bus.branch_n    <= 1'b1;
    end else begin
      bus <= next_bus;
    end
  end

  // Zero wait states; OKAY always
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hrdata    = bus.rdata;
  assign ahb_rsp.hresp     = 1'b0;
  assign device_chosen_n   = bus.chosen_n;
  assign branch_enabled_n  = bus.branch_n;
  assign self_test_n       = bus.self_test_n;

endmodule : scgw_top

// *** scgw_monitor.sv ***
// Checker for scan gateway pin control
`timescale 1ns/1ps
module scgw_monitor
  import scgw_pkg::*;
(
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                upstream_test_reset_n,
  input wire logic                upstream_fast_write_in,
  input wire logic                upstream_data_out_oe,
  input wire logic                port_output_enable_n,
  input wire logic                port_reset_n,
  input wire logic                direct_route_enable_n,
  input wire logic [2:0]          direct_route_select,
  input wire scgw_pkg::scgw_lsp_t port_out,
  input wire logic                device_chosen_n,
  input wire logic                branch_enabled_n,
  input wire logic                self_test_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Codes 110 and 111 shift out of range, so no port is hit
  wire logic [5:0] hit = 6'h01 << direct_route_select;
  wire logic       on  = !direct_route_enable_n;
  wire logic       p6  = on && direct_route_select == 3'h5;
  sequence s_link_reset;
    $fell(upstream_test_reset_n) || $fell(port_reset_n);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_fast_write_gate: assert property (!p6 |-> !port_out.fast_write_oe[5])
    else $error("port 6 fast write driven off route");
  a_fast_write_pass: assert property (p6 && port_out.fast_write_oe[5] |->
    port_out.fast_write[5] == upstream_fast_write_in)
    else $error("fast write not passed through");
  a_debug_idle: assert property (!p6 |-> port_out.debug_enable_n[5])
    else $error("port 6 debug enable low off route");
  a_data_out_off: assert property (
    !upstream_test_reset_n |-> !upstream_data_out_oe)
    else $error("data out driven during link reset");
  a_ports_quiet: assert property (!port_output_enable_n |->
    (port_out.drive_oe | port_out.fast_write_oe) == 6'h00)
    else $error("ports driven while disabled");
  a_port_trst: assert property (!port_reset_n |-> port_out.trst_n == 6'h00)
    else $error("port test reset not low");
  a_chosen_pair: assert property (device_chosen_n == branch_enabled_n)
    else $error("chosen and enabled differ");
  a_chosen_drop: assert property (s_link_reset |-> ##[1:4] device_chosen_n)
    else $error("chosen not dropped after link reset");
  a_self_single: assert property ($fell(self_test_n) |=> $rose(self_test_n))
    else $error("self test pulse longer than one cycle");
  a_route_only: assert property (on |->
    (port_out.drive_oe & ~hit) == 6'h00 && (port_out.debug_enable_n | hit) == 6'h3f)
    else $error("unselected port driven");
endmodule : scgw_monitor

bind scgw_top scgw_monitor scgw_monitor_i (.*);

// *** scgw_master.sv ***
// Backplane test master model on the upstream scan port
`timescale 1ns/1ps
module scgw_master (
  output logic upstream_test_clock,
  output logic upstream_mode_in,
  output logic upstream_data_in
);
  initial begin
    upstream_test_clock = 1'b0;
    upstream_mode_in = 1'b0;
    upstream_data_in = 1'b0;
  end
  // frames name the target slot; clock idles low between frames
  task automatic send(input logic [7:0] cmd);
    for (int i = 0; i < 9; i++) begin
      upstream_mode_in = (i < 8);
      upstream_data_in = (i < 8) ? cmd[i] : ~upstream_data_in;
      #6 upstream_test_clock = 1'b1;
      #6 upstream_test_clock = 1'b0;
    end
  endtask : send
endmodule : scgw_master

// *** test_scan_gateway_pin_control.sv ***
// Self-checking bench for scan gateway pin control
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_scan_gateway_pin_control;
  import scgw_pkg::*;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  scgw_ahb_req_t ahb_req = '0;
  scgw_ahb_rsp_t ahb_rsp;
  scgw_lsp_t     port_out;
  logic          upstream_test_clock;
  logic          upstream_mode_in;
  logic          upstream_data_in;
  logic          upstream_test_reset_n = 1'b0;
  logic          upstream_fast_write_in = 1'b1;
  logic          upstream_data_out;
  logic          upstream_data_out_oe;
  logic [5:0]    slot_address = 6'h2a;
  logic          port_output_enable_n = 1'b1;
  logic          port_reset_n = 1'b1;
  logic          direct_route_enable_n = 1'b1;
  logic [2:0]    direct_route_select = 3'h0;
  logic [7:0]    status_in = 8'ha5;
  logic [5:0]    port_data_in = 6'h2c;
  logic          device_chosen_n;
  logic          branch_enabled_n;
  logic          self_test_n;
  logic [31:0]   rd;
  int            bad_count = 0;
  int            n_tests = 0;
  int            cyc = 0;
  always #2.5 clock = ~clock;
  // Also woken by the clock so the constant hready is never missed at time 0
  always @(ahb_rsp.hreadyout or posedge clock) begin
    ahb_req.hready = ahb_rsp.hreadyout;
  end
  scgw_master scgw_master_i (.*);
  // slot address strapped as on a backplane
  scgw_top scgw_top_i (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    ahb_req.hsel <= 1'b1;
    ahb_req.htrans <= 2'h2;
    ahb_req.haddr <= {24'h0, a};
    ahb_req.hwrite <= wr;
    ahb_req.hsize <= 3'h2;
    do @(posedge clock); while (ahb_rsp.hreadyout !== 1'b1);
    ahb_req.htrans <= 2'h0;
    ahb_req.hwdata <= wd;
    do @(posedge clock); while (ahb_rsp.hreadyout !== 1'b1);
    rd = ahb_rsp.hrdata;
  endtask : bus
  task automatic t_select();
    scgw_master_i.send({scgw_op_select, 6'h15});
    repeat (5) @(posedge clock);
    `CHK(device_chosen_n, 1'b1)
    scgw_master_i.send({scgw_op_select, slot_address});
    repeat (5) @(posedge clock);
    `CHK({device_chosen_n, branch_enabled_n, upstream_data_out_oe}, 3'h1)
    bus(1'b0, scgw_state_offset, 32'h0);
    `CHK(rd, {17'h0, slot_address, status_in, 1'b1})
    // Unmapped offset reads as zero
    bus(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0)
  endtask : t_select
  task automatic t_route();
    logic [5:0] m;
    @(posedge clock);
    direct_route_enable_n <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      @(posedge clock);
      direct_route_select <= c[2:0];
      // Checked before the next edge: path must not be registered
      #1;
      m = (c < 6) ? 6'h01 << c : 6'h00;
      `CHK(port_out.drive_oe, m)
      `CHK(port_out.debug_enable_n, ~m)
      `CHK({port_out.fast_write_oe, port_out.fast_write & m}, {m, m})
      if (c < 6) `CHK(upstream_data_out, port_data_in[c])
    end
    @(posedge clock);
    direct_route_enable_n <= 1'b1;
    #1;
    `CHK({port_out.drive_oe, port_out.fast_write_oe,
          port_out.debug_enable_n}, 18'h3f03f)
    @(posedge clock);
    port_output_enable_n <= 1'b0;
    #1;
    `CHK(port_out.drive_oe, 6'h00)
    @(posedge clock);
    port_output_enable_n <= 1'b1;
    bus(1'b1, scgw_ctrl_offset, 32'h0);
    #1;
    `CHK(port_out.drive_oe, 6'h00)
    bus(1'b1, scgw_ctrl_offset, 32'h1);
  endtask : t_route
  task automatic t_self();
    int k = 0;
    scgw_master_i.send({scgw_op_self_test, 6'h00});
    while (self_test_n !== 1'b0 && k < 20) begin
      @(posedge clock);
      k++;
    end
    `CHK(self_test_n, 1'b0)
    bus(1'b0, scgw_count_offset, 32'h0);
    `CHK(rd[7:0], 8'h01)
  endtask : t_self
  task automatic t_resets();
    @(posedge clock);
    port_reset_n <= 1'b0;
    #1;
    `CHK({port_out.trst_n, upstream_data_out_oe}, 7'h00)
    @(posedge clock);
    port_reset_n <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK(device_chosen_n, 1'b1)
    scgw_master_i.send({scgw_op_select, slot_address});
    `CHK(upstream_data_out_oe, 1'b1)
    @(posedge clock);
    upstream_test_reset_n <= 1'b0;
    #1;
    `CHK(upstream_data_out_oe, 1'b0)
    @(posedge clock);
    upstream_test_reset_n <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK(device_chosen_n, 1'b1)
  endtask : t_resets
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    upstream_test_reset_n <= 1'b1;
    @(posedge clock);
    #1;
    `CHK({device_chosen_n, self_test_n, upstream_data_out_oe}, 3'h6)
    bus(1'b0, scgw_ctrl_offset, 32'h0);
    `CHK(rd, 32'h1)
    t_select();
    t_route();
    t_self();
    t_resets();
    finish_test();
  end
endmodule : test_scan_gateway_pin_control
